// >>> hw/supervisor_defines.svh
// Register map, field positions, codes and timing of the supervisor block
`ifndef SUPERVISOR_DEFINES_SVH
`define SUPERVISOR_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_MODE 6'h00
`define OFS_WAKE_CFG 6'h04
`define OFS_WAKE_STAT 6'h08
`define OFS_CLK_CFG 6'h0C
`define OFS_DIV_CFG 6'h10
`define OFS_RTC_COUNT 6'h14
`define OFS_RTC_ALARM 6'h18

// ----------------------------------------
// Mode codes
// ----------------------------------------
`define MODE_RUN_FAST 3'h0
`define MODE_RUN_SLOW 3'h1
`define MODE_STANDBY 3'h2
`define MODE_SLEEP 3'h3
`define MODE_SHUTDOWN 3'h4
`define MODE_STARTUP 3'h7

// ----------------------------------------
// Fields
// ----------------------------------------
`define WAKE_SRC_BITS 5
`define WAKE_ALARM_BIT 4
`define WAKE_SLOW_BIT 5
`define CLK_SRC_BIT 0
`define CLK_FREQ_LSB 1
`define CLK_FREQ_MSB 6
`define FREQ_DEFAULT 6'h00
`define FREQ_MIN 6'h01
`define FREQ_MAX 6'h28

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_MHZ 25
`define STARTUP_NS 100000
`define STARTUP_CYC ((`STARTUP_NS * `CLK_MHZ + 999) / 1000)

`endif

// >>> hw/supervisor_pkg.sv
// Types shared by the supervisor block
package supervisor_pkg;

	typedef enum logic [2:0] {
		ST_STARTUP,
		ST_RUN_FAST,
		ST_RUN_SLOW,
		ST_STANDBY,
		ST_SLEEP,
		ST_SHUTDOWN
	} power_state_t;

endpackage

// >>> hw/supervisor_wakeup_clock_sequencer.sv
// Supervisor, wakeup, clock selection and real-time clock with AHB-Lite registers
// Operation
// RULE1 - Start-up delay and reset thresholds handled on chip, no external parts.
// RULE2 - In run modes, core supply loss forces a device reset.
// RULE3 - Supervisor switched off in standby, sleep and shutdown.
// RULE4 - Wakeup moves from standby, sleep or shutdown into a run mode.
// RULE5 - At most four external wakeup sources.
// RULE6 - Dedicated wake pin wakes on a rising edge.
// RULE7 - Three multipurpose pins wake: two on rising, one on falling edge.
// RULE8 - Alarm can wake the device from standby or sleep.
// RULE9 - Alarm also raises an interrupt to the processor.
// RULE10 - After power-on, internal oscillator at 10.24 MHz is the system clock.
// RULE11 - Software may select the 32.768 kHz crystal as system clock.
// RULE12 - Oscillator settings 1 to 40 MHz selectable by software in run.
// RULE13 - Software configures the PLL before use; it free-runs until then.
// RULE14 - Software recalibrates the PLL when reference stops or lock lost.
// RULE15 - Real-time clock keeps counting in all low-power modes.
// RULE16 - Real-time clock cleared only by power-on reset.
// RULE17 - Processor, sensor and peripheral dividers are set independently.
// RULE18 - Leaving sleep resets the system and restarts boot.
// RULE19 - Power-on reset release enables the core supply regulator.
// RULE20 - Wake edges caught by always-on logic before run sequence starts.
`timescale 1ns/10ps
`include "supervisor_defines.svh"

module supervisor_wakeup_clock_sequencer
	import supervisor_pkg::*;
(
	input wire logic clock_in,
	input wire logic reset_n_in,
	input wire logic core_supply_rail_ok_in,
	input wire logic wake_pin_in,
	input wire logic [2:0] multipurpose_pin_in,
	input wire logic xtal_tick_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	output logic system_reset_n_out,
	output logic core_regulator_en_out,
	output logic supervisor_en_out,
	output logic [2:0] mode_out,
	output logic clock_source_out,
	output logic [5:0] osc_freq_out,
	output logic [7:0] cpu_div_out,
	output logic [7:0] sensor_div_out,
	output logic [7:0] periph_div_out,
	output logic rtc_alarm_irq_out
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	power_state_t state_reg, state_next;
	logic [11:0] start_cnt_reg;
	logic wr_pend_reg;
	logic [5:0] wr_addr_reg;
	logic [5:0] wake_cfg_reg;
	logic [4:0] wake_stat_reg;
	logic [6:0] clk_cfg_reg;
	logic [23:0] div_cfg_reg;
	logic [31:0] rtc_count_reg;
	logic [31:0] rtc_alarm_reg;
	logic wake_pin_prev_reg;
	logic [2:0] mp_prev_reg;
	logic [4:0] wake_event;
	logic [4:0] wake_allowed;
	logic wake_now;
	logic rtc_hit;
	logic addr_phase;
	logic [31:0] rd_mux;
	logic [2:0] mode_req;
	logic mode_wr;
	logic [5:0] freq_wr;

	assign addr_phase = hsel_in && htrans_in[1] && hready_in;
	assign mode_wr = wr_pend_reg && wr_addr_reg == `OFS_MODE;
	assign mode_req = hwdata_in[2:0];
	assign freq_wr = hwdata_in[`CLK_FREQ_MSB:`CLK_FREQ_LSB];

	// ----------------------------------------
	// Wake edge capture
	// ----------------------------------------
	// Held only by power-on reset, so a wake cause survives the boot restart
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wake_pin_prev_reg <= 1'b0;
			mp_prev_reg <= 3'h7;
		end else begin
			wake_pin_prev_reg <= wake_pin_in;
			mp_prev_reg <= multipurpose_pin_in;
		end
	end

	assign rtc_hit = xtal_tick_in && rtc_count_reg == rtc_alarm_reg;
	assign wake_event[0] = wake_pin_in && !wake_pin_prev_reg; // RULE6
	assign wake_event[1] = multipurpose_pin_in[0] && !mp_prev_reg[0]; // RULE7
	assign wake_event[2] = multipurpose_pin_in[1] && !mp_prev_reg[1]; // RULE7
	assign wake_event[3] = !multipurpose_pin_in[2] && mp_prev_reg[2]; // RULE7
	assign wake_event[4] = rtc_hit;

	// Set wins over a same-cycle clear
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wake_stat_reg <= 5'h00;
		end else if (wr_pend_reg && wr_addr_reg == `OFS_WAKE_STAT) begin
			wake_stat_reg <= (wake_stat_reg & ~hwdata_in[4:0]) | wake_event; // RULE20
		end else begin
			wake_stat_reg <= wake_stat_reg | wake_event; // RULE20
		end
	end

	// Alarm wakes only from standby or sleep; four pin sources at most
	always_comb begin
		wake_allowed = wake_stat_reg & wake_cfg_reg[4:0]; // RULE5
		if (state_reg == ST_SHUTDOWN) begin
			wake_allowed[`WAKE_ALARM_BIT] = 1'b0; // RULE8
		end
	end
	assign wake_now = |wake_allowed;

	// ----------------------------------------
	// Power state sequencing
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_STARTUP: begin
				if (start_cnt_reg == 12'(`STARTUP_CYC - 1)) begin
					state_next = ST_RUN_FAST; // RULE1
				end
			end
			ST_RUN_FAST, ST_RUN_SLOW: begin
				if (!core_supply_rail_ok_in) begin
					state_next = ST_STARTUP; // RULE2
				end else if (mode_wr) begin
					case (mode_req)
						`MODE_RUN_FAST: state_next = ST_RUN_FAST;
						`MODE_RUN_SLOW: state_next = ST_RUN_SLOW;
						`MODE_STANDBY: state_next = ST_STANDBY;
						`MODE_SLEEP: state_next = ST_SLEEP;
						`MODE_SHUTDOWN: state_next = ST_SHUTDOWN;
						default: state_next = state_reg;
					endcase
				end
			end
			ST_STANDBY: begin
				if (wake_now) begin
					state_next = wake_cfg_reg[`WAKE_SLOW_BIT] ? ST_RUN_SLOW : ST_RUN_FAST; // RULE4
				end
			end
			ST_SLEEP, ST_SHUTDOWN: begin
				if (wake_now) begin
					state_next = ST_STARTUP; // RULE18
				end
			end
			default: state_next = ST_STARTUP;
		endcase
	end

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_reg <= ST_STARTUP;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			start_cnt_reg <= 12'h000;
		end else if (state_next == ST_STARTUP && state_reg == ST_STARTUP) begin
			start_cnt_reg <= start_cnt_reg + 12'h001; // RULE1
		end else begin
			start_cnt_reg <= 12'h000;
		end
	end

	// Outputs follow the next state so they line up with state_reg
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			system_reset_n_out <= 1'b0;
			core_regulator_en_out <= 1'b0;
			supervisor_en_out <= 1'b0;
			mode_out <= `MODE_STARTUP;
		end else begin
			system_reset_n_out <= state_next != ST_STARTUP; // RULE18
			core_regulator_en_out <= state_next != ST_SLEEP && state_next != ST_SHUTDOWN; // RULE19
			supervisor_en_out <= state_next == ST_RUN_FAST || state_next == ST_RUN_SLOW; // RULE3
			case (state_next)
				ST_RUN_FAST: mode_out <= `MODE_RUN_FAST;
				ST_RUN_SLOW: mode_out <= `MODE_RUN_SLOW;
				ST_STANDBY: mode_out <= `MODE_STANDBY;
				ST_SLEEP: mode_out <= `MODE_SLEEP;
				ST_SHUTDOWN: mode_out <= `MODE_SHUTDOWN;
				default: mode_out <= `MODE_STARTUP;
			endcase
		end
	end

	// ----------------------------------------
	// Clock source and dividers
	// ----------------------------------------
	// Re-entering startup restores the boot clock, as after power-on
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			clk_cfg_reg <= 7'h00;
		end else if (state_reg == ST_STARTUP) begin
			clk_cfg_reg <= 7'h00; // RULE10
		end else if (wr_pend_reg && wr_addr_reg == `OFS_CLK_CFG) begin
			clk_cfg_reg[`CLK_SRC_BIT] <= hwdata_in[`CLK_SRC_BIT]; // RULE11
			if (freq_wr == `FREQ_DEFAULT || (freq_wr >= `FREQ_MIN && freq_wr <= `FREQ_MAX)) begin
				clk_cfg_reg[`CLK_FREQ_MSB:`CLK_FREQ_LSB] <= freq_wr; // RULE12
			end
		end
	end

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			div_cfg_reg <= 24'h000000;
		end else if (state_reg == ST_STARTUP) begin
			div_cfg_reg <= 24'h000000;
		end else if (wr_pend_reg && wr_addr_reg == `OFS_DIV_CFG) begin
			div_cfg_reg <= hwdata_in[23:0]; // RULE17
		end
	end

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			clock_source_out <= 1'b0;
			osc_freq_out <= `FREQ_DEFAULT;
			cpu_div_out <= 8'h00;
			sensor_div_out <= 8'h00;
			periph_div_out <= 8'h00;
		end else begin
			clock_source_out <= clk_cfg_reg[`CLK_SRC_BIT];
			osc_freq_out <= clk_cfg_reg[`CLK_FREQ_MSB:`CLK_FREQ_LSB];
			cpu_div_out <= div_cfg_reg[7:0]; // RULE17
			sensor_div_out <= div_cfg_reg[15:8]; // RULE17
			periph_div_out <= div_cfg_reg[23:16]; // RULE17
		end
	end

	// ----------------------------------------
	// Real-time clock
	// ----------------------------------------
	// No system reset term: only power-on clears it
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rtc_count_reg <= 32'h00000000; // RULE16
		end else if (wr_pend_reg && wr_addr_reg == `OFS_RTC_COUNT) begin
			rtc_count_reg <= hwdata_in;
		end else if (xtal_tick_in) begin
			rtc_count_reg <= rtc_count_reg + 32'h00000001; // RULE15
		end
	end

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rtc_alarm_reg <= 32'hFFFFFFFF;
			wake_cfg_reg <= 6'h00;
		end else if (wr_pend_reg && wr_addr_reg == `OFS_RTC_ALARM) begin
			rtc_alarm_reg <= hwdata_in;
		end else if (wr_pend_reg && wr_addr_reg == `OFS_WAKE_CFG) begin
			wake_cfg_reg <= hwdata_in[5:0];
		end
	end

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rtc_alarm_irq_out <= 1'b0;
		end else begin
			rtc_alarm_irq_out <= wake_stat_reg[`WAKE_ALARM_BIT] | rtc_hit; // RULE9
		end
	end

	// ----------------------------------------
	// AHB-Lite slave
	// ----------------------------------------
	always_comb begin
		rd_mux = 32'h00000000;
		case (haddr_in[5:0])
			`OFS_MODE: rd_mux = {29'h00000000, mode_out};
			`OFS_WAKE_CFG: rd_mux = {26'h0000000, wake_cfg_reg};
			`OFS_WAKE_STAT: rd_mux = {27'h0000000, wake_stat_reg};
			`OFS_CLK_CFG: rd_mux = {25'h0000000, clk_cfg_reg};
			`OFS_DIV_CFG: rd_mux = {8'h00, div_cfg_reg};
			`OFS_RTC_COUNT: rd_mux = rtc_count_reg;
			`OFS_RTC_ALARM: rd_mux = rtc_alarm_reg;
			default: rd_mux = 32'h00000000;
		endcase
		if (haddr_in[31:6] != 26'h0000000) begin
			rd_mux = 32'h00000000;
		end
	end

	// Zero wait states; unmapped addresses read zero and drop writes
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 6'h3F;
			hrdata_out <= 32'h00000000;
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
		end else begin
			wr_pend_reg <= addr_phase && hwrite_in && haddr_in[31:6] == 26'h0000000;
			wr_addr_reg <= haddr_in[5:0];
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
			if (addr_phase && !hwrite_in) begin
				hrdata_out <= rd_mux;
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!reset_n_in);

	logic run_now;
	assign run_now = state_reg == ST_RUN_FAST || state_reg == ST_RUN_SLOW;

	sequence seq_sleep_wake;
		state_reg == ST_SLEEP && wake_now;
	endsequence

	sequence seq_boot_restart;
		!system_reset_n_out ##1 state_reg == ST_STARTUP;
	endsequence

	chk_startup_delay: assert property ($rose(system_reset_n_out) |->
		$past(start_cnt_reg) == 12'(`STARTUP_CYC - 1)) // RULE1
		else $error("reset released before start-up delay");
	chk_supply_reset: assert property (run_now && !core_supply_rail_ok_in |=>
		!system_reset_n_out && state_reg == ST_STARTUP) // RULE2
		else $error("supply loss did not reset device");
	chk_supervisor_off: assert property (!run_now |-> !supervisor_en_out) // RULE3
		else $error("supervisor active outside run");
	chk_standby_wake: assert property (state_reg == ST_STANDBY && wake_now |=>
		run_now && system_reset_n_out) // RULE4
		else $error("standby wake did not reach run");
	chk_pin_rise: assert property (wake_pin_in && !wake_pin_prev_reg |=>
		wake_stat_reg[0]) // RULE6
		else $error("wake pin rise not recorded");
	chk_mp_fall: assert property ($fell(multipurpose_pin_in[2]) |=> wake_stat_reg[3]) // RULE7
		else $error("falling wake pin not recorded");
	chk_alarm_irq: assert property (rtc_hit |=> rtc_alarm_irq_out ##1 rtc_alarm_irq_out) // RULE9
		else $error("alarm interrupt missing");
	chk_shutdown_alarm: assert property (state_reg == ST_SHUTDOWN &&
		wake_stat_reg == 5'h10 |=> state_reg == ST_SHUTDOWN) // RULE8
		else $error("alarm woke device from shutdown");
	chk_boot_clock: assert property (state_reg == ST_STARTUP ##1 state_reg == ST_STARTUP |=>
		!clock_source_out && osc_freq_out == `FREQ_DEFAULT) // RULE10
		else $error("boot clock not default oscillator");
	chk_rtc_runs: assert property (xtal_tick_in && !(wr_pend_reg &&
		wr_addr_reg == `OFS_RTC_COUNT) |=> rtc_count_reg == $past(rtc_count_reg) + 32'h1) // RULE15
		else $error("real-time clock missed a tick");
	chk_sleep_boot: assert property (seq_sleep_wake |=> seq_boot_restart) // RULE18
		else $error("sleep exit did not restart boot");
	chk_regulator_on: assert property ($past(reset_n_in) && state_reg == ST_STARTUP |-> // RULE19
		core_regulator_en_out) else $error("core regulator off after reset release");

endmodule

// >>> verification/wake_source_model.sv
// Model of wake pins, crystal ticks and core supply
`timescale 1ns/10ps

module wake_source_model #(
	parameter int TICK_DIV = 16
) (
	input wire logic clock_in,
	output logic wake_pin_out,
	output logic [2:0] mp_pin_out,
	output logic xtal_tick_out,
	output logic supply_ok_out
);
	int tick_cnt = 0;
	// Idle: rising-edge pins low, falling-edge pin high
	initial begin
		wake_pin_out = 1'b0;
		mp_pin_out = 3'h4;
		xtal_tick_out = 1'b0;
		supply_ok_out = 1'b1;
	end
	// Crystal runs in every mode
	always @(posedge clock_in) begin
		tick_cnt <= (tick_cnt == TICK_DIV - 1) ? 0 : tick_cnt + 1;
		xtal_tick_out <= (tick_cnt == TICK_DIV - 1);
	end
	// Active edge, held a few cycles, then back to idle
	task automatic fire(input int idx);
		if (idx == 0) begin
			wake_pin_out <= 1'b1;
		end else begin
			mp_pin_out <= mp_pin_out ^ 3'(1 << (idx - 1));
		end
		repeat (3) @(posedge clock_in);
		wake_pin_out <= 1'b0;
		mp_pin_out <= 3'h4;
	endtask
	task automatic drop_supply();
		supply_ok_out <= 1'b0;
		@(posedge clock_in);
		supply_ok_out <= 1'b1;
	endtask
endmodule

// >>> verification/tb.sv
// Self-checking bench for the supervisor, wakeup and clock block
`timescale 1ns/10ps
`include "supervisor_defines.svh"

module tb;
	logic clock_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, rd;
	logic hready, hresp, sys_rst_n, reg_en, sup_en, clk_src, wake_pin, tick, sup_ok, irq;
	logic [2:0] mode, mp_pin;
	logic [5:0] freq;
	logic [7:0] cpu_div, sen_div, per_div;
	logic [2:0] lp_mode [4] = '{`MODE_STANDBY, `MODE_SLEEP, `MODE_SHUTDOWN, `MODE_STANDBY};
	int num_errors = 0;
	int n_tests = 0;
	int cycles = 0;
	int k;

	always #20 clock_in = ~clock_in;

	wake_source_model src_u (.clock_in(clock_in), .wake_pin_out(wake_pin),
		.mp_pin_out(mp_pin), .xtal_tick_out(tick), .supply_ok_out(sup_ok));

	supervisor_wakeup_clock_sequencer dut_u (.clock_in(clock_in), .reset_n_in(reset_n_in),
		.core_supply_rail_ok_in(sup_ok), .wake_pin_in(wake_pin), .multipurpose_pin_in(mp_pin),
		.xtal_tick_in(tick), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
		.hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
		.hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
		.system_reset_n_out(sys_rst_n), .core_regulator_en_out(reg_en),
		.supervisor_en_out(sup_en), .mode_out(mode), .clock_source_out(clk_src),
		.osc_freq_out(freq), .cpu_div_out(cpu_div), .sensor_div_out(sen_div),
		.periph_div_out(per_div), .rtc_alarm_irq_out(irq));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		do @(posedge clock_in); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock_in); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	task automatic rdc(input string name, input logic [31:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(name, rd, exp);
		check("hresp", hresp, 1'b0);
	endtask

	// Bounded wait, ends at a falling edge
	task automatic wait_mode(input logic [2:0] m);
		k = 0;
		@(negedge clock_in);
		while (mode !== m && k < 4000) begin
			@(negedge clock_in);
			k++;
		end
		check("mode_out", mode, m);
	endtask

	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Whole run is some 16000 cycles
	always @(posedge clock_in) begin
		cycles++;
		if (cycles == 40000) begin
			num_errors++;
			test_done();
		end
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge clock_in);
		@(negedge clock_in);
		check("sys_rst_n", sys_rst_n, 1'b0);
		check("reg_en", reg_en, 1'b0);
		@(posedge clock_in);
		reset_n_in <= 1'b1;
		k = 0;
		@(negedge clock_in);
		while (sys_rst_n !== 1'b1 && k < 4000) begin
			@(negedge clock_in);
			k++;
		end
		check("startup_len", k >= 2490 && k <= 2510, 1'b1);
		check("mode", mode, `MODE_RUN_FAST);
		check("clk_src", clk_src, 1'b0);
		check("freq", freq, `FREQ_DEFAULT);
		check("reg_en", reg_en, 1'b1);
		check("sup_en", sup_en, 1'b1);
		$display("Test startup done");

		@(posedge clock_in);
		rdc("alarm", `OFS_RTC_ALARM, 32'hFFFFFFFF);
		rdc("unmapped", 32'h1C, 32'h0);
		bus(1'b1, `OFS_CLK_CFG, 32'h51);
		bus(1'b1, `OFS_CLK_CFG, 32'h53);
		bus(1'b1, `OFS_DIV_CFG, 32'h00332211);
		// Divider outputs follow the register one edge later
		@(posedge clock_in);
		@(negedge clock_in);
		check("clk_src", clk_src, 1'b1);
		check("freq", freq, `FREQ_MAX);
		check("cpu_div", cpu_div, 8'h11);
		check("sen_div", sen_div, 8'h22);
		check("per_div", per_div, 8'h33);
		@(posedge clock_in);
		bus(1'b1, `OFS_CLK_CFG, 32'h02);
		rdc("clk_cfg", `OFS_CLK_CFG, 32'h02);
		bus(1'b1, `OFS_MODE, 32'h1);
		wait_mode(`MODE_RUN_SLOW);
		check("sup_en", sup_en, 1'b1);
		@(posedge clock_in);
		bus(1'b1, `OFS_MODE, 32'h0);
		bus(1'b1, `OFS_RTC_COUNT, 32'h100);
		repeat (40) @(posedge clock_in);
		bus(1'b0, `OFS_RTC_COUNT, 32'h0);
		check("rtc_runs", rd > 32'h100, 1'b1);
		$display("Test registers done");

		for (int i = 0; i < 4; i++) begin
			bus(1'b1, `OFS_WAKE_CFG, (32'h1 << i) | {26'h0, i == 3, 5'h0});
			bus(1'b1, `OFS_MODE, {29'h0, lp_mode[i]});
			wait_mode(lp_mode[i]);
			check("sup_en", sup_en, 1'b0);
			check("reg_en", reg_en, lp_mode[i] == `MODE_STANDBY);
			@(posedge clock_in);
			src_u.drop_supply();
			src_u.fire((i + 1) % 4);
			repeat (4) @(posedge clock_in);
			@(negedge clock_in);
			check("no_wake", mode, lp_mode[i]);
			check("no_reset", sys_rst_n, 1'b1);
			@(posedge clock_in);
			src_u.fire(i);
			if (lp_mode[i] != `MODE_STANDBY) begin
				wait_mode(`MODE_STARTUP);
				check("sys_rst_n", sys_rst_n, 1'b0);
			end
			wait_mode(i == 3 ? `MODE_RUN_SLOW : `MODE_RUN_FAST);
			@(posedge clock_in);
			rdc("wake_stat", `OFS_WAKE_STAT, (32'h1 << i) | (32'h1 << ((i + 1) % 4)));
			bus(1'b1, `OFS_WAKE_STAT, 32'h1F);
		end
		$display("Test wake pins done");

		// Alarm fires in shutdown but must not wake; a pin does
		bus(1'b1, `OFS_RTC_ALARM, 32'h4);
		bus(1'b1, `OFS_RTC_COUNT, 32'h0);
		bus(1'b1, `OFS_WAKE_CFG, 32'h14);
		bus(1'b1, `OFS_MODE, {29'h0, `MODE_SHUTDOWN});
		repeat (100) @(posedge clock_in);
		@(negedge clock_in);
		check("alarm_shutdown", mode, `MODE_SHUTDOWN);
		@(posedge clock_in);
		src_u.fire(2);
		wait_mode(`MODE_RUN_FAST);
		@(posedge clock_in);
		bus(1'b1, `OFS_WAKE_STAT, 32'h1F);

		bus(1'b1, `OFS_RTC_ALARM, 32'h4);
		bus(1'b1, `OFS_RTC_COUNT, 32'h0);
		bus(1'b1, `OFS_WAKE_CFG, 32'h10);
		bus(1'b1, `OFS_MODE, {29'h0, `MODE_SLEEP});
		wait_mode(`MODE_STARTUP);
		wait_mode(`MODE_RUN_FAST);
		check("irq", irq, 1'b1);
		@(posedge clock_in);
		rdc("wake_stat", `OFS_WAKE_STAT, 32'h10);
		bus(1'b0, `OFS_RTC_COUNT, 32'h0);
		check("rtc_kept", rd > 32'h80, 1'b1);
		bus(1'b1, `OFS_WAKE_STAT, 32'h10);
		@(posedge clock_in);
		@(negedge clock_in);
		check("irq", irq, 1'b0);
		$display("Test alarm done");

		@(posedge clock_in);
		bus(1'b1, `OFS_CLK_CFG, 32'h51);
		src_u.drop_supply();
		@(negedge clock_in);
		check("sys_rst_n", sys_rst_n, 1'b0);
		wait_mode(`MODE_RUN_FAST);
		check("clk_src", clk_src, 1'b0);
		@(posedge clock_in);
		bus(1'b1, `OFS_CLK_CFG, 32'h51);
		bus(1'b0, `OFS_RTC_COUNT, 32'h0);
		check("rtc_kept", rd > 32'h100, 1'b1);
		@(negedge clock_in);
		check("clk_src", clk_src, 1'b1);
		check("freq", freq, `FREQ_MAX);
		$display("Test supply loss done");
		test_done();
	end
endmodule
